//--- dtid_decoder.v
// Summary of operation
// - fan three-wire: firestat open forces preset one
// - firestat closed, freezestat open: preset two
// - both closed: keypad or command source
// - enable open: coast immediately, no decel
// - process: forward enable gates forward running
// - process: reverse enable gates reverse running
// - process: both enables open decelerate stop
// - process: table select picks parameter set
// - process: ramp group two or torque mode
// - stop in torque mode: zero current
// - process: loop enable PID, feedforward always on
// - process: jog allowed in enabled direction
// - process: fault reset input resets, blocks run
// - external trip honoured only when enabled
// - two-wire: forward or reverse, decel otherwise
// - two-wire: both closed resets fault
// - two-wire: analog one or command source
// - run source, fan and two-wire: terminals closed, keypad open
// - two-wire: speed source command or keypad
// - source switch holds speed and direction for one cycle
// - two-wire: preset table from two selects
// - unipolar: motion unless both closed
`include "dtid_consts.vh"

module dtid_decoder #(
    parameter SYNC_STAGES = `DTID_SYNC_STAGES
) (
    input wire clk_sys,
    input wire srst,
    input wire [`DTID_MODE_W-1:0] op_mode,
    input wire ext_trip_protect_on,
    input wire cmd_source_is_analog1,
    input wire cmd_source_unipolar,
    input wire vector_control,
    input wire keypad_run,
    input wire [`DTID_DIR_W-1:0] keypad_dir,
    input wire keypad_fault_reset,
    input wire [`DTID_DIR_W-1:0] proc_cmd_dir,
    input wire enable_input,
    input wire forward_input,
    input wire reverse_input,
    input wire select_input_a,
    input wire select_input_b,
    input wire select_input_c,
    input wire select_input_d,
    input wire select_input_e,
    input wire external_trip_input,
    output reg drive_enable_r,
    output reg [`DTID_DIR_W-1:0] run_dir_r,
    output reg [`DTID_STOP_W-1:0] stop_style_r,
    output reg [`DTID_SRC_W-1:0] speed_src_r,
    output reg fault_reset_r,
    output reg ext_trip_fault_r,
    output reg param_set2_r,
    output reg ramp_group2_r,
    output reg torque_mode_r,
    output reg pid_enable_r,
    output reg integrator_clear_r,
    output reg feedforward_path_r,
    output reg jog_mode_r,
    output reg terminal_run_src_r,
    output reg hold_speed_r
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam NI = `DTID_NUM_INPUTS;
    wire [NI-1:0] raw_in;
    wire [NI-1:0] syn;
    assign raw_in = {external_trip_input, select_input_e, select_input_d,
                     select_input_c, select_input_b, select_input_a,
                     reverse_input, forward_input, enable_input};

    // contacts change with no regard to clk_sys: two flops at least
    genvar gi;
    generate
        for (gi = 0; gi < NI; gi = gi + 1) begin : g_sync
            reg [SYNC_STAGES-1:0] sh_r;
            always @(posedge clk_sys) begin
                if (srst) begin
                    sh_r <= {SYNC_STAGES{1'b0}};
                end else begin
                    sh_r <= {sh_r[SYNC_STAGES-2:0], raw_in[gi]};
                end
            end
            assign syn[gi] = sh_r[SYNC_STAGES-1];
        end
    endgenerate

    wire en_s = syn[0];
    wire fwd_s = syn[1];
    wire rev_s = syn[2];
    wire sa_s = syn[3];
    wire sb_s = syn[4];
    wire sc_s = syn[5];
    wire sd_s = syn[6];
    wire se_s = syn[7];
    wire trip_s = syn[8];

    // ************************************************************
    // decode
    // ************************************************************
    reg en_nxt;
    reg [`DTID_DIR_W-1:0] dir_nxt;
    reg [`DTID_STOP_W-1:0] stop_nxt;
    reg [`DTID_SRC_W-1:0] src_nxt;
    reg frst_nxt;
    reg trip_nxt;
    reg pset_nxt;
    reg ramp_nxt;
    reg torq_nxt;
    reg pid_nxt;
    reg iclr_nxt;
    reg ff_nxt;
    reg jog_nxt;
    reg trun_nxt;
    reg hold_nxt;
    reg term_run;
    reg term_spd;
    reg [`DTID_DIR_W-1:0] want_dir;
    reg term_spd_r;

    always @* begin
        en_nxt = en_s;
        dir_nxt = `DTID_DIR_NONE;
        stop_nxt = `DTID_STOP_DECEL;
        src_nxt = `DTID_SRC_KEYPAD;
        frst_nxt = 1'b0;
        trip_nxt = ext_trip_protect_on & ~trip_s;
        pset_nxt = 1'b0;
        ramp_nxt = 1'b0;
        torq_nxt = 1'b0;
        pid_nxt = 1'b0;
        iclr_nxt = 1'b0;
        ff_nxt = 1'b0;
        jog_nxt = 1'b0;
        trun_nxt = 1'b0;
        hold_nxt = 1'b0;
        term_run = 1'b0;
        term_spd = 1'b0;
        want_dir = `DTID_DIR_NONE;
        // other modes' assignments are never looked at
        case (op_mode)
            `DTID_MODE_FAN3W: begin
                term_run = sb_s;
                term_spd = sc_s;
                if (!sd_s) begin
                    src_nxt = `DTID_SRC_PRESET1;
                end else if (!se_s) begin
                    src_nxt = `DTID_SRC_PRESET2;
                end else if (sc_s) begin
                    src_nxt = `DTID_SRC_CMDPAR;
                end else begin
                    src_nxt = `DTID_SRC_KEYPAD;
                end
                if (!sb_s) begin
                    want_dir = keypad_run ? keypad_dir : `DTID_DIR_NONE;
                end else if (fwd_s && rev_s) begin
                    frst_nxt = 1'b1;
                end else if (fwd_s) begin
                    want_dir = `DTID_DIR_FWD;
                end else if (rev_s) begin
                    want_dir = `DTID_DIR_REV;
                end else begin
                    want_dir = run_dir_r;
                end
                if (sb_s && !sa_s) begin
                    want_dir = `DTID_DIR_NONE;
                end
            end
            `DTID_MODE_PROC: begin
                term_run = 1'b1;
                term_spd = 1'b1;
                src_nxt = `DTID_SRC_CMDPAR;
                pset_nxt = sa_s;
                ramp_nxt = sb_s & ~vector_control;
                torq_nxt = sb_s & vector_control;
                pid_nxt = sc_s;
                iclr_nxt = ~sc_s;
                ff_nxt = 1'b1;
                // jog needs at least one direction enabled
                jog_nxt = sd_s & (fwd_s | rev_s);
                frst_nxt = se_s;
                // a direction runs only while its own enable is closed
                if (proc_cmd_dir == `DTID_DIR_FWD && fwd_s) begin
                    want_dir = `DTID_DIR_FWD;
                end else if (proc_cmd_dir == `DTID_DIR_REV && rev_s) begin
                    want_dir = `DTID_DIR_REV;
                end else begin
                    want_dir = `DTID_DIR_NONE;
                end
                if (se_s) begin
                    want_dir = `DTID_DIR_NONE;
                end
            end
            `DTID_MODE_SPD2W: begin
                term_run = sb_s;
                term_spd = sc_s;
                if (!sc_s) begin
                    src_nxt = `DTID_SRC_KEYPAD;
                end else begin
                    case ({se_s, sd_s})
                        2'h1: src_nxt = `DTID_SRC_PRESET1;
                        2'h2: src_nxt = `DTID_SRC_PRESET2;
                        2'h3: src_nxt = `DTID_SRC_PRESET3;
                        default: begin
                            if (sa_s || cmd_source_is_analog1) begin
                                src_nxt = `DTID_SRC_ANALOG1;
                            end else begin
                                src_nxt = `DTID_SRC_CMDPAR;
                            end
                        end
                    endcase
                end
                if (!sb_s) begin
                    want_dir = keypad_run ? keypad_dir : `DTID_DIR_NONE;
                end else if (fwd_s && rev_s) begin
                    frst_nxt = 1'b1;
                end else if (fwd_s) begin
                    want_dir = `DTID_DIR_FWD;
                end else if (rev_s) begin
                    want_dir = `DTID_DIR_REV;
                end
                // unipolar source gives no sign; both closed is reset
                if (cmd_source_unipolar && fwd_s && rev_s) begin
                    want_dir = `DTID_DIR_NONE;
                end
            end
            default: begin
                want_dir = `DTID_DIR_NONE;
            end
        endcase
        if (!term_run) begin
            frst_nxt = keypad_fault_reset;
        end
        trun_nxt = term_run;
        // hand-over between terminals and keypad: hold one cycle
        // so a source swap never drops the running direction
        if (term_run != terminal_run_src_r || term_spd != term_spd_r) begin
            hold_nxt = 1'b1;
            want_dir = run_dir_r;
        end
        dir_nxt = want_dir;
        if (!en_s) begin
            stop_nxt = `DTID_STOP_COAST;
            dir_nxt = `DTID_DIR_NONE;
        end else if (want_dir != `DTID_DIR_NONE) begin
            stop_nxt = `DTID_STOP_RUN;
        end else if (torq_nxt) begin
            stop_nxt = `DTID_STOP_ZEROI;
        end else begin
            stop_nxt = `DTID_STOP_DECEL;
        end
    end

    // ************************************************************
    // enable, direction and stop outputs
    // ************************************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            drive_enable_r <= 1'b0;
            run_dir_r <= `DTID_DIR_NONE;
            stop_style_r <= `DTID_STOP_COAST;
        end else begin
            drive_enable_r <= en_nxt;
            run_dir_r <= dir_nxt;
            stop_style_r <= stop_nxt;
        end
    end

    // ************************************************************
    // speed source outputs
    // ************************************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            speed_src_r <= `DTID_SRC_KEYPAD;
            hold_speed_r <= 1'b0;
        end else begin
            speed_src_r <= src_nxt;
            hold_speed_r <= hold_nxt;
        end
    end

    // ************************************************************
    // fault outputs
    // ************************************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            fault_reset_r <= 1'b0;
            ext_trip_fault_r <= 1'b0;
        end else begin
            fault_reset_r <= frst_nxt;
            ext_trip_fault_r <= trip_nxt;
        end
    end

    // ************************************************************
    // parameter set and ramp outputs
    // ************************************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            param_set2_r <= 1'b0;
            ramp_group2_r <= 1'b0;
            torque_mode_r <= 1'b0;
        end else begin
            param_set2_r <= pset_nxt;
            ramp_group2_r <= ramp_nxt;
            torque_mode_r <= torq_nxt;
        end
    end

    // ************************************************************
    // loop and jog outputs
    // ************************************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            pid_enable_r <= 1'b0;
            integrator_clear_r <= 1'b1;
            feedforward_path_r <= 1'b0;
            jog_mode_r <= 1'b0;
        end else begin
            pid_enable_r <= pid_nxt;
            integrator_clear_r <= iclr_nxt;
            feedforward_path_r <= ff_nxt;
            jog_mode_r <= jog_nxt;
        end
    end

    // ************************************************************
    // source tracking
    // ************************************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            terminal_run_src_r <= 1'b0;
            term_spd_r <= 1'b0;
        end else begin
            terminal_run_src_r <= trun_nxt;
            term_spd_r <= term_spd;
        end
    end

endmodule // dtid_decoder

//--- dtid_consts.vh
`ifndef DTID_CONSTS_VH
`define DTID_CONSTS_VH
// operating modes
`define DTID_MODE_W 2
`define DTID_MODE_FAN3W 2'h0
`define DTID_MODE_PROC 2'h1
`define DTID_MODE_SPD2W 2'h2
// speed source codes
`define DTID_SRC_W 3
`define DTID_SRC_KEYPAD 3'h0
`define DTID_SRC_CMDPAR 3'h1
`define DTID_SRC_PRESET1 3'h2
`define DTID_SRC_PRESET2 3'h3
`define DTID_SRC_PRESET3 3'h4
`define DTID_SRC_ANALOG1 3'h5
// direction codes
`define DTID_DIR_W 2
`define DTID_DIR_NONE 2'h0
`define DTID_DIR_FWD 2'h1
`define DTID_DIR_REV 2'h2
// stop style codes
`define DTID_STOP_W 2
`define DTID_STOP_RUN 2'h0
`define DTID_STOP_DECEL 2'h1
`define DTID_STOP_COAST 2'h2
`define DTID_STOP_ZEROI 2'h3
// synchroniser depth and input count
`define DTID_SYNC_STAGES 2
`define DTID_NUM_INPUTS 9
`endif

//--- dtid_switches.sv
// ****
// contact bank at the terminal strip
// ****
module dtid_switches (
    input wire logic clk_sys,
    input wire logic [8:0] want,
    output wire logic enable_input, forward_input, reverse_input,
    output wire logic select_input_a, select_input_b, select_input_c,
    output wire logic select_input_d, select_input_e, external_trip_input
);
    timeunit 1ns;
    timeprecision 100ps;
    // contacts settle one edge late, never in step with the request
    logic [8:0] q = 9'h101;
    always @(posedge clk_sys) begin
        q <= want;
    end
    assign {enable_input, forward_input, reverse_input, select_input_a,
            select_input_b, select_input_c, select_input_d, select_input_e,
            external_trip_input} = q;
endmodule // dtid_switches

//--- dtid_checker.sv
`include "dtid_consts.vh"
// ****
// decode checks
// ****
module dtid_checker (
    input wire clk_sys, srst,
    input wire [1:0] op_mode, run_dir_r, stop_style_r,
    input wire [2:0] speed_src_r,
    input wire ext_trip_protect_on, cmd_source_is_analog1,
    input wire enable_input, forward_input, reverse_input,
    input wire select_input_a, select_input_b, select_input_c,
    input wire select_input_d, select_input_e, external_trip_input,
    input wire drive_enable_r, fault_reset_r, ext_trip_fault_r,
    input wire param_set2_r
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire fan = op_mode == 2'h0;
    wire two = op_mode == 2'h2;
    wire [1:0] sw = {select_input_d, select_input_e};
    // a tripped drive may refuse to run, so keep protection off here
    wire go2 = two && enable_input && select_input_b && select_input_c &&
        !ext_trip_protect_on;
    // terminals take 3 edges; longer windows cover the source hold cycle
    chk_coast_open: assert property (
        (!enable_input && op_mode != 2'h3) [*4]
        |-> stop_style_r == `DTID_STOP_COAST && !drive_enable_r)
        else $error("no coast");
    chk_fire_first: assert property (
        (fan && !select_input_d) [*4] |-> speed_src_r == `DTID_SRC_PRESET1)
        else $error("firestat speed");
    chk_freeze_second: assert property (
        (fan && sw == 2'h2) [*4] |-> speed_src_r == `DTID_SRC_PRESET2)
        else $error("freezestat speed");
    chk_table_pick: assert property (
        (op_mode == 2'h1 && $stable(select_input_a)) [*4]
        |-> param_set2_r == select_input_a)
        else $error("parameter set");
    chk_trip_raise: assert property (
        (ext_trip_protect_on && !external_trip_input) [*4]
        |-> ext_trip_fault_r)
        else $error("no trip");
    chk_two_fwd: assert property (
        (go2 && forward_input && !reverse_input) [*6]
        |-> run_dir_r == `DTID_DIR_FWD && stop_style_r == `DTID_STOP_RUN)
        else $error("no forward run");
    chk_both_reset: assert property (
        (two && select_input_b && forward_input && reverse_input) [*6]
        |-> fault_reset_r && run_dir_r == `DTID_DIR_NONE)
        else $error("both closed");
    chk_preset_table: assert property (
        (go2 && !select_input_a && !cmd_source_is_analog1 && $stable(sw))
        [*4] |-> speed_src_r == (sw == 2'h2 ? `DTID_SRC_PRESET1 :
        sw == 2'h1 ? `DTID_SRC_PRESET2 : sw == 2'h3 ? `DTID_SRC_PRESET3 :
        `DTID_SRC_CMDPAR))
        else $error("preset table");
    cover property (ext_trip_fault_r);
    cover property (run_dir_r == `DTID_DIR_REV);
    cover property (fan && sw == 2'h3 && select_input_c);
endmodule // dtid_checker

bind dtid_decoder dtid_checker i_dtid_checker (.*);

//--- drive_terminal_input_decoder_tb.sv
`include "dtid_consts.vh"
module drive_terminal_input_decoder_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, srst, hs, dn;
    logic [1:0] op_mode;
    logic [9:0] cfg;
    logic [8:0] want;
    wire ext_trip_protect_on, cmd_source_is_analog1, cmd_source_unipolar;
    wire vector_control, keypad_run, keypad_fault_reset;
    wire [1:0] keypad_dir, proc_cmd_dir, run_dir_r, stop_style_r;
    wire [2:0] speed_src_r;
    wire enable_input, forward_input, reverse_input, select_input_a;
    wire select_input_b, select_input_c, select_input_d, select_input_e;
    wire external_trip_input, drive_enable_r, fault_reset_r;
    wire ext_trip_fault_r, param_set2_r, ramp_group2_r, torque_mode_r;
    wire pid_enable_r, integrator_clear_r, feedforward_path_r;
    wire jog_mode_r, terminal_run_src_r, hold_speed_r;
    int errors, checks_done;
    assign {ext_trip_protect_on, cmd_source_is_analog1, cmd_source_unipolar,
            vector_control, keypad_run, keypad_dir, keypad_fault_reset,
            proc_cmd_dir} = cfg;
    dtid_decoder i_dtid_decoder (.*);
    dtid_switches i_dtid_switches (.*);
    // ****
    // helpers
    // ****
    task automatic chk(input string n, input logic [3:0] s, e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    // apply mode, config and contacts, then watch the settling window
    task automatic go(input logic [1:0] m, input logic [9:0] c,
                      input logic [8:0] v);
        @(posedge clk_sys);
        op_mode <= m;
        cfg <= c;
        want <= v;
        repeat (7) begin
            @(posedge clk_sys);
            #1;
            hs = hs | hold_speed_r;
            dn = dn | (run_dir_r == `DTID_DIR_NONE);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_fan;
        go(2'h0, 10'h0, 9'h13b);
        chk("fire", speed_src_r, `DTID_SRC_PRESET1);
        go(2'h0, 10'h0, 9'h13d);
        chk("freeze", speed_src_r, `DTID_SRC_PRESET2);
        go(2'h0, 10'h0, 9'h137);
        chk("keypad", speed_src_r, `DTID_SRC_KEYPAD);
        go(2'h0, 10'h0, 9'h13f);
        chk("cmdsrc", speed_src_r, `DTID_SRC_CMDPAR);
        $display("test fan done");
    endtask
    task automatic t_proc;
        go(2'h1, 10'h041, 9'h1b9);
        chk("fwd", run_dir_r, `DTID_DIR_FWD);
        chk("set2", param_set2_r, 1'b1);
        chk("torque", torque_mode_r, 1'b1);
        chk("pid", pid_enable_r, 1'b1);
        chk("ff", feedforward_path_r, 1'b1);
        go(2'h1, 10'h040, 9'h1b9);
        chk("zeroi", stop_style_r, `DTID_STOP_ZEROI);
        go(2'h1, 10'h002, 9'h151);
        chk("rev", run_dir_r, `DTID_DIR_REV);
        chk("ramp2", ramp_group2_r, 1'b1);
        chk("set1", param_set2_r, 1'b0);
        chk("iclr", integrator_clear_r, 1'b1);
        go(2'h1, 10'h002, 9'h191);
        chk("rev_off", stop_style_r, `DTID_STOP_DECEL);
        go(2'h1, 10'h001, 9'h111);
        chk("both_off", stop_style_r, `DTID_STOP_DECEL);
        go(2'h1, 10'h001, 9'h185);
        chk("jog", jog_mode_r, 1'b1);
        go(2'h1, 10'h001, 9'h105);
        chk("jog_off", jog_mode_r, 1'b0);
        go(2'h1, 10'h001, 9'h183);
        chk("freset", fault_reset_r, 1'b1);
        chk("blocked", run_dir_r, `DTID_DIR_NONE);
        $display("test process done");
    endtask
    task automatic t_two;
        logic [1:0] i;
        go(2'h2, 10'h080, 9'h199);
        chk("fwd2", run_dir_r, `DTID_DIR_FWD);
        chk("run2", stop_style_r, `DTID_STOP_RUN);
        chk("tsrc", terminal_run_src_r, 1'b1);
        go(2'h2, 10'h080, 9'h159);
        chk("rev2", run_dir_r, `DTID_DIR_REV);
        go(2'h2, 10'h080, 9'h1d9);
        chk("both", fault_reset_r, 1'b1);
        chk("still", run_dir_r, `DTID_DIR_NONE);
        go(2'h2, 10'h080, 9'h119);
        chk("decel2", stop_style_r, `DTID_STOP_DECEL);
        for (i = 2'h0; i != 2'h3; i++) begin
            go(2'h2, 10'h0, 9'h119 | {6'h0, i + 2'h1, 1'b0});
            chk("preset", speed_src_r, i == 2'h1 ? `DTID_SRC_PRESET1 :
                i == 2'h0 ? `DTID_SRC_PRESET2 : `DTID_SRC_PRESET3);
        end
        go(2'h2, 10'h0, 9'h139);
        chk("an_sel", speed_src_r, `DTID_SRC_ANALOG1);
        go(2'h2, 10'h100, 9'h119);
        chk("an_src", speed_src_r, `DTID_SRC_ANALOG1);
        go(2'h2, 10'h0, 9'h111);
        chk("kp_spd", speed_src_r, `DTID_SRC_KEYPAD);
        go(2'h2, 10'h028, 9'h199);
        hs = 1'b0;
        dn = 1'b0;
        go(2'h2, 10'h028, 9'h189);
        chk("hold", hs, 1'b1);
        chk("kept", dn, 1'b0);
        chk("kp_run", terminal_run_src_r, 1'b0);
        go(2'h2, 10'h030, 9'h189);
        chk("kp_dir", run_dir_r, `DTID_DIR_REV);
        $display("test two-wire done");
    endtask
    task automatic t_misc;
        go(2'h2, 10'h0, 9'h099);
        chk("coast", stop_style_r, `DTID_STOP_COAST);
        chk("disabled", drive_enable_r, 1'b0);
        go(2'h3, 10'h0, 9'h199);
        chk("idle", run_dir_r, `DTID_DIR_NONE);
        go(2'h2, 10'h0, 9'h118);
        chk("trip_off", ext_trip_fault_r, 1'b0);
        go(2'h2, 10'h200, 9'h118);
        chk("trip_on", ext_trip_fault_r, 1'b1);
        $display("test misc done");
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        srst = 1'b1;
        op_mode = 2'h3;
        cfg = 10'h0;
        want = 9'h101;
        hs = 1'b0;
        dn = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1;
        chk("rst_stop", stop_style_r, `DTID_STOP_COAST);
        srst <= 1'b0;
        t_fan;
        t_proc;
        t_two;
        t_misc;
        wrap_up;
    end
    initial begin
        repeat (1500) @(posedge clk_sys);
        errors++;
        wrap_up;
    end
endmodule // drive_terminal_input_decoder_tb
